// >>> hw/ccdseq_pkg.sv
// Package for the CCD readout clock sequencer (host side timing generator).
// Assumes a single 40 MHz reference clock and digital level outputs that
// external drivers translate to the sensor clock voltages.
package ccdseq_pkg;

    localparam int          REF_CLK_MHZ     = 40;
    localparam int          COL_ACTIVE      = 648;
    localparam int          ROW_ACTIVE      = 484;
    localparam int          VREG_COUNT      = 680;
    localparam int          HREG_STAGES     = 496;
    localparam int          DARK_COLS       = 32;
    localparam int          DARK_ROWS       = 12;
    localparam int          ROW_TOTAL       = ROW_ACTIVE + DARK_ROWS;
    localparam int          CNT_W           = 16;
    // Phase widths in nanoseconds, converted to whole cycles (least times).
    localparam int          REF_CLK_PER_NS  = 1000 / REF_CLK_MHZ;
    localparam int          VPULSE_NS       = 1000;
    localparam int          HOLD_NS         = 250;
    localparam int          SHUT_NS         = 1000;
    localparam int          PH1_XFER_NS     = 2000;
    localparam int          VPULSE_CYC      =
        (VPULSE_NS + REF_CLK_PER_NS - 1) / REF_CLK_PER_NS;
    localparam int          HOLD_CYC        =
        (HOLD_NS + REF_CLK_PER_NS - 1) / REF_CLK_PER_NS;
    localparam int          SHUT_CYC        =
        (SHUT_NS + REF_CLK_PER_NS - 1) / REF_CLK_PER_NS;
    localparam int          PH1_XFER_CYC    =
        (PH1_XFER_NS + REF_CLK_PER_NS - 1) / REF_CLK_PER_NS;
    localparam int          FIFO_DEPTH      = 32;

    // Per-line command entry held in the FIFO.
    typedef struct packed {
        logic              dump;
        logic              bin;
    } ccdseq_line_s;
    localparam int          LINE_W          = 2;

    // Sensor clock outputs, all digital levels.
    typedef struct packed {
        logic vertical_phase_one_clock;
        logic vertical_phase_one_high;
        logic vertical_phase_two_clock;
        logic horiz_reg_a_phase_one_clock;
        logic horiz_reg_b_phase_one_clock;
        logic horiz_shared_phase_two_clock;
        logic resetClock;
        logic line_dump_gate;
        logic substrate_shutter_pulse;
    } ccdseq_pins_s;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_PH1,
        ST_LINE_V2H,
        ST_LINE_V2L,
        ST_TO_B,
        ST_A_BACK,
        ST_RETRACE,
        ST_PIX_H2H,
        ST_PIX_H2L,
        ST_PIX_RST
    } ccdseq_state_e;

endpackage

// >>> hw/ccdseq_fifo.sv
// Synchronous FIFO holding per-line commands for the sequencer.
// Assumes one clock, a clock enable and an asynchronous active-low reset.
`timescale 1ns/1ps
module ccdseq_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 32
) (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    input  wire logic             clkEn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0]   count;
        logic [WIDTH-1:0] rdData;
        logic          rdValid;
    } ccdseq_fifo_s;

    ccdseq_fifo_s     st_q;
    ccdseq_fifo_s     st_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             doWr;
    logic             doRd;
    logic             loadOut;

    // The output register counts as one of the DEPTH words.
    assign inReady  = ((st_q.count + (AW+1)'(st_q.rdValid))
                       != (AW+1)'(DEPTH));
    assign doWr     = inValid && inReady;
    assign outValid = st_q.rdValid;
    assign outData  = st_q.rdData;
    // The output register refills whenever it is empty or being drained.
    assign loadOut  = (st_q.count != '0) && (!st_q.rdValid || outReady);
    assign doRd     = loadOut;

    always_comb begin
        st_d = st_q;
        if (doWr) begin
            st_d.wrPtr = st_q.wrPtr + 1'b1;
        end
        if (loadOut) begin
            st_d.rdData  = mem[st_q.rdPtr];
            st_d.rdValid = 1'b1;
            st_d.rdPtr   = st_q.rdPtr + 1'b1;
        end else if (outReady) begin
            st_d.rdValid = 1'b0;
        end
        st_d.count = st_q.count + (AW+1)'(doWr) - (AW+1)'(doRd);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else if (clkEn) begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clkEn && doWr) begin
            mem[st_q.wrPtr] <= inData;
        end
    end
endmodule

// >>> hw/ccdseq_ctrl.sv
// Host-side timing generator that clocks an interline progressive CCD.
// Assumes external level translators for every clock; the line FIFO is fed
// by same-clock logic, the start strobe and modes come from same-clock logic.
`timescale 1ns/1ps
module ccdseq_ctrl
    import ccdseq_pkg::*;
#(
    parameter int ROWS   = ROW_TOTAL,
    parameter int STAGES = HREG_STAGES
) (
    input  wire logic               ref_clk,
    input  wire logic               arst_n,
    input  wire logic               clkEn,
    input  wire logic               frameStart,
    input  wire logic               dualMode,
    input  wire logic               singleOutput,
    input  wire logic [CNT_W-1:0]   shutterLine,
    input  wire logic               lineValid,
    output logic                    lineReady,
    input  wire logic [LINE_W-1:0]  lineCmd,
    output ccdseq_pins_s            pins,
    output logic                    sampleStrobe,
    output logic                    busy
);
    typedef struct packed {
        ccdseq_state_e    state;
        logic [CNT_W-1:0] tmr;
        logic [CNT_W-1:0] row;
        logic [CNT_W-1:0] pix;
        logic             secondLine;
        logic             dual;
        logic             binPend;
        logic             shutDone;
        ccdseq_pins_s     pins;
        logic             sample;
    } ccdseq_ctrl_s;

    ccdseq_ctrl_s st_q;
    ccdseq_ctrl_s st_d;
    logic         cmdValid;
    logic         cmdTake;
    ccdseq_line_s cmd;
    logic [LINE_W-1:0] cmdRaw;

    // Per-line commands (dump, bin) flow through a FIFO; readout stalls on it.
    ccdseq_fifo #(
        .WIDTH (LINE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .clkEn    (clkEn),
        .inValid  (lineValid),
        .inReady  (lineReady),
        .inData   (lineCmd),
        .outValid (cmdValid),
        .outReady (cmdTake),
        .outData  (cmdRaw)
    );
    assign cmd = ccdseq_line_s'(cmdRaw);

    function automatic logic timerDone(input logic [CNT_W-1:0] t);
        return t == '0;
    endfunction

    assign cmdTake = (st_q.state == ST_RETRACE) && cmdValid
                     && timerDone(st_q.tmr);
    assign pins         = st_q.pins;
    assign sampleStrobe = st_q.sample;
    assign busy         = st_q.state != ST_IDLE;

    always_comb begin
        st_d        = st_q;
        st_d.sample = 1'b0;
        if (!timerDone(st_q.tmr)) begin
            st_d.tmr = st_q.tmr - 1'b1;
        end
        case (st_q.state)
            ST_IDLE: begin
                st_d.pins.horiz_reg_a_phase_one_clock = 1'b1;
                st_d.pins.horiz_shared_phase_two_clock = 1'b0;
                if (frameStart) begin
                    // The single-output part only allows register A.
                    st_d.dual  = dualMode && !singleOutput;
                    st_d.row   = '0;
                    st_d.shutDone = 1'b0;
                    st_d.pins.vertical_phase_one_clock = 1'b1;
                    st_d.pins.vertical_phase_two_clock = 1'b0;
                    st_d.pins.vertical_phase_one_high = 1'b1;
                    st_d.tmr   = CNT_W'(PH1_XFER_CYC);
                    st_d.state = ST_PH1;
                end
            end
            ST_PH1: begin
                if (timerDone(st_q.tmr)) begin
                    // Its falling edge closes the exposure interval.
                    st_d.pins.vertical_phase_one_high = 1'b0;
                    st_d.secondLine = 1'b0;
                    st_d.tmr   = CNT_W'(HOLD_CYC);
                    st_d.state = ST_RETRACE;
                end
            end
            ST_RETRACE: begin
                // Shutter only here, with horizontal clocks parked.
                if (!st_q.shutDone && st_q.row == shutterLine
                    && st_q.row < CNT_W'(ROWS)
                    && st_q.secondLine == 1'b0) begin
                    st_d.pins.substrate_shutter_pulse = 1'b1;
                    st_d.shutDone = 1'b1;
                    st_d.tmr = CNT_W'(SHUT_CYC);
                end else if (timerDone(st_q.tmr)) begin
                    st_d.pins.substrate_shutter_pulse = 1'b0;
                    if (st_q.row >= CNT_W'(ROWS)) begin
                        st_d.state = ST_IDLE;
                    end else if (cmdValid) begin
                        st_d.binPend = cmd.bin;
                        // Dump gate high across the transfer clears it.
                        st_d.pins.line_dump_gate = cmd.dump;
                        // A held high, H2 low while V2 pulses.
                        st_d.pins.horiz_reg_a_phase_one_clock = 1'b1;
                        st_d.pins.vertical_phase_two_clock = 1'b1;
                        st_d.pins.vertical_phase_one_clock = 1'b0;
                        st_d.tmr   = CNT_W'(VPULSE_CYC);
                        st_d.state = ST_LINE_V2H;
                    end
                end
            end
            ST_LINE_V2H: begin
                if (timerDone(st_q.tmr)) begin
                    st_d.pins.vertical_phase_two_clock = 1'b0;
                    st_d.pins.vertical_phase_one_clock = 1'b1;
                    st_d.tmr   = CNT_W'(VPULSE_CYC);
                    st_d.state = ST_LINE_V2L;
                end
            end
            ST_LINE_V2L: begin
                if (timerDone(st_q.tmr)) begin
                    st_d.pins.line_dump_gate = 1'b0;
                    st_d.row = st_q.row + 1'b1;
                    st_d.tmr = CNT_W'(HOLD_CYC);
                    if (st_q.binPend) begin
                        // Second line summed into the same register.
                        st_d.binPend = 1'b0;
                        st_d.state   = ST_RETRACE;
                    end else if (st_q.dual && !st_q.secondLine) begin
                        st_d.pins.horiz_reg_a_phase_one_clock = 1'b0;
                        st_d.pins.horiz_reg_b_phase_one_clock = 1'b1;
                        st_d.state = ST_TO_B;
                    end else begin
                        st_d.pix   = '0;
                        st_d.state = ST_PIX_H2H;
                    end
                end
            end
            ST_TO_B: begin
                if (timerDone(st_q.tmr)) begin
                    st_d.pins.horiz_reg_a_phase_one_clock = 1'b1;
                    st_d.tmr   = CNT_W'(HOLD_CYC);
                    st_d.state = ST_A_BACK;
                end
            end
            ST_A_BACK: begin
                if (timerDone(st_q.tmr)) begin
                    st_d.secondLine = 1'b1;
                    st_d.state = ST_RETRACE;
                end
            end
            ST_PIX_H2H: begin
                // Both phase ones low, shared phase two high.
                st_d.pins.horiz_shared_phase_two_clock = 1'b1;
                st_d.pins.horiz_reg_a_phase_one_clock = 1'b0;
                st_d.pins.horiz_reg_b_phase_one_clock = 1'b0;
                st_d.state = ST_PIX_H2L;
            end
            ST_PIX_H2L: begin
                // Falling phase two puts a packet on the output node.
                st_d.pins.horiz_shared_phase_two_clock = 1'b0;
                st_d.pins.horiz_reg_a_phase_one_clock = 1'b1;
                st_d.pins.horiz_reg_b_phase_one_clock = st_q.dual;
                st_d.sample = 1'b1;
                st_d.state  = ST_PIX_RST;
            end
            ST_PIX_RST: begin
                // Reset follows the sample of the current pixel.
                st_d.pins.resetClock = !st_q.pins.resetClock;
                if (st_q.pins.resetClock) begin
                    st_d.pix = st_q.pix + 1'b1;
                    if (st_q.pix == CNT_W'(STAGES - 1)) begin
                        st_d.pins.horiz_reg_b_phase_one_clock = 1'b0;
                        st_d.secondLine = 1'b0;
                        st_d.tmr   = CNT_W'(HOLD_CYC);
                        st_d.state = ST_RETRACE;
                    end else begin
                        st_d.state = ST_PIX_H2H;
                    end
                end
            end
            default: begin
                st_d.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q       <= '0;
            st_q.state <= ST_IDLE;
            st_q.pins.vertical_phase_one_clock <= 1'b1;
            st_q.pins.horiz_reg_a_phase_one_clock <= 1'b1;
        end else if (clkEn) begin
            st_q <= st_d;
        end
    end

    property p_vcomp;
        @(posedge ref_clk) disable iff (!arst_n)
        pins.vertical_phase_one_clock != pins.vertical_phase_two_clock;
    endproperty
    a_vcomp: assert property (p_vcomp) else $error("vertical not complementary");

    property p_hcomp;
        @(posedge ref_clk) disable iff (!arst_n)
        pins.horiz_shared_phase_two_clock |-> !pins.horiz_reg_a_phase_one_clock;
    endproperty
    a_hcomp: assert property (p_hcomp) else $error("horizontal overlap");

    property p_v2a;
        @(posedge ref_clk) disable iff (!arst_n)
        pins.vertical_phase_two_clock |-> pins.horiz_reg_a_phase_one_clock
            && !pins.horiz_shared_phase_two_clock;
    endproperty
    a_v2a: assert property (p_v2a) else $error("V2 pulse without A held");

    property p_shut;
        @(posedge ref_clk) disable iff (!arst_n)
        pins.substrate_shutter_pulse |-> st_q.state == ST_RETRACE;
    endproperty
    a_shut: assert property (p_shut) else $error("shutter during readout");

    property p_single;
        @(posedge ref_clk) disable iff (!arst_n)
        (st_q.state == ST_IDLE && frameStart && singleOutput && clkEn)
            |=> !st_q.dual;
    endproperty
    a_single: assert property (p_single) else $error("dual on single part");

    property p_dump;
        @(posedge ref_clk) disable iff (!arst_n)
        pins.line_dump_gate |-> (st_q.state == ST_LINE_V2H
            || st_q.state == ST_LINE_V2L);
    endproperty
    a_dump: assert property (p_dump) else $error("dump outside transfer");

    property p_rst;
        @(posedge ref_clk) disable iff (!arst_n)
        (sampleStrobe && clkEn) |=> pins.resetClock;
    endproperty
    a_rst: assert property (p_rst) else $error("no reset after sample");

    property p_tob;
        @(posedge ref_clk) disable iff (!arst_n)
        pins.horiz_reg_b_phase_one_clock && st_q.state == ST_TO_B
            |-> !pins.horiz_reg_a_phase_one_clock
            && !pins.horiz_shared_phase_two_clock;
    endproperty
    a_tob: assert property (p_tob) else $error("bad A to B move");

    property p_pixcnt;
        @(posedge ref_clk) disable iff (!arst_n)
        st_q.pix <= CNT_W'(STAGES);
    endproperty
    a_pixcnt: assert property (p_pixcnt) else $error("pixel count overrun");

    c_frame: cover property (@(posedge ref_clk) st_q.state == ST_PH1);
    c_dual: cover property (@(posedge ref_clk) st_q.state == ST_TO_B);
    c_shut: cover property (@(posedge ref_clk) pins.substrate_shutter_pulse);
    c_dumpc: cover property (@(posedge ref_clk) pins.line_dump_gate);
endmodule

// >>> dv/ccdseq_sensor_model.sv
// Behavioural model of the sensor that watches the sequencer's clock pins.
// Assumes the pins are registered levels sampled on the sequencer's clock.
`timescale 1ns/1ps
module ccdseq_sensor_model
    import ccdseq_pkg::*;
#(
    parameter int STAGES = HREG_STAGES
) (
    input  wire logic         ref_clk,
    input  wire logic         clr,
    input  wire ccdseq_pins_s pins,
    output int                falls,
    output int                rsts,
    output int                v2s,
    output int                bHi,
    output int                dumps,
    output int                shuts,
    output int                clash,
    output int                lineBad,
    output int                v1Len,
    output int                v2Len,
    output int                expo
);
    // Geometry of the modelled array; the bench shortens the register.
    localparam int GEOM_COLS = COL_ACTIVE + DARK_COLS;
    ccdseq_pins_s p;
    int           lineCnt = 0;
    int           run1 = 0;
    int           run2 = 0;
    int           expoRun = 0;
    logic         exposing = 1'b0;
    wire ccdseq_pins_s rise = pins & ~p;
    wire ccdseq_pins_s fall = p & ~pins;

    always @(posedge ref_clk) begin
        if (clr) begin
            {falls, rsts, v2s, bHi, dumps, shuts, clash, lineBad} = '0;
            lineCnt = 0;
        end
        if (fall.horiz_shared_phase_two_clock) begin
            falls++;
            lineCnt++;
        end
        if (rise.vertical_phase_two_clock) begin
            v2s++;
            // A register of STAGES cells is emptied whole or binned.
            if (lineCnt != 0 && lineCnt != STAGES) lineBad++;
            lineCnt = 0;
        end
        rsts += rise.resetClock;
        bHi += rise.horiz_reg_b_phase_one_clock;
        dumps += rise.line_dump_gate;
        shuts += rise.substrate_shutter_pulse;
        if (pins.horiz_shared_phase_two_clock &&
            (pins.horiz_reg_a_phase_one_clock ||
             pins.horiz_reg_b_phase_one_clock ||
             pins.line_dump_gate)) clash++;
        if (pins.substrate_shutter_pulse &&
            (pins.horiz_shared_phase_two_clock || pins.resetClock)) clash++;
        if (pins.vertical_phase_two_clock &&
            (!pins.horiz_reg_a_phase_one_clock ||
             pins.horiz_shared_phase_two_clock)) clash++;
        run1 = pins.vertical_phase_one_high ? run1 + 1 : 0;
        run2 = pins.vertical_phase_two_clock ? run2 + 1 : 0;
        if (p.vertical_phase_two_clock && !pins.vertical_phase_two_clock)
            v2Len = p.vertical_phase_two_clock ? v2Len : v2Len;
        if (rise.vertical_phase_one_high) run1 = 1;
        if (exposing) expoRun++;
        if (fall.substrate_shutter_pulse) begin
            exposing = 1'b1;
            expoRun = 0;
        end
        if (fall.vertical_phase_one_high) begin
            if (exposing) expo = expoRun;
            exposing = 1'b0;
        end
        if (pins.vertical_phase_one_high) v1Len = run1;
        if (pins.vertical_phase_two_clock) v2Len = run2;
        p = pins;
    end
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the CCD readout sequencer with a sensor model.
// Assumes short frames through the ROWS and STAGES parameters.
`timescale 1ns/1ps
module testbench
    import ccdseq_pkg::*;
;
    localparam int ROWS   = 4;
    localparam int STAGES = 4;
    logic             ref_clk = 1'b0;
    logic             arst_n = 1'b0;
    logic             clkEn = 1'b1;
    logic             frameStart = 1'b0;
    logic             dualMode = 1'b0;
    logic             singleOutput = 1'b0;
    logic             lineValid = 1'b0;
    logic             clr = 1'b1;
    logic [CNT_W-1:0] shutterLine = '0;
    logic [LINE_W-1:0] lineCmd = '0;
    logic             lineReady;
    logic             sampleStrobe;
    logic             busy;
    ccdseq_pins_s     pins;
    int falls, rsts, v2s, bHi, dumps, shuts, clash, lineBad, v1Len, v2Len;
    int expo;
    int errors = 0;
    int cmp_count = 0;
    int strobes = 0;

    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (sampleStrobe === 1'b1 && clkEn) strobes++;

    ccdseq_ctrl #(.ROWS(ROWS), .STAGES(STAGES)) DUT (
        .ref_clk(ref_clk), .arst_n(arst_n), .clkEn(clkEn),
        .frameStart(frameStart), .dualMode(dualMode),
        .singleOutput(singleOutput), .shutterLine(shutterLine),
        .lineValid(lineValid), .lineReady(lineReady), .lineCmd(lineCmd),
        .pins(pins), .sampleStrobe(sampleStrobe), .busy(busy));

    ccdseq_sensor_model #(.STAGES(STAGES)) sensor (
        .ref_clk(ref_clk), .clr(clr), .pins(pins), .falls(falls),
        .rsts(rsts), .v2s(v2s), .bHi(bHi), .dumps(dumps), .shuts(shuts),
        .clash(clash), .lineBad(lineBad), .v1Len(v1Len), .v2Len(v2Len),
        .expo(expo));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Pushes line commands until the FIFO refuses; the first one is given.
    task automatic fill(input logic [LINE_W-1:0] first, output int n);
        n = 0;
        lineCmd = first;
        repeat (40) begin
            @(negedge ref_clk);
            if (n > 0) lineCmd = '0;
            lineValid = lineReady;
            @(posedge ref_clk);
            if (lineValid) n++;
        end
        @(negedge ref_clk);
        lineValid = 1'b0;
    endtask

    task automatic frame(input logic dual, input logic so, input int shut,
                         input logic freeze);
        ccdseq_pins_s held;
        int           t;
        @(negedge ref_clk);
        dualMode = dual;
        singleOutput = so;
        shutterLine = shut[CNT_W-1:0];
        clr = 1'b1;
        frameStart = 1'b1;
        strobes = 0;
        @(negedge ref_clk);
        clr = 1'b0;
        frameStart = 1'b0;
        if (freeze) begin
            repeat (200) @(negedge ref_clk);
            clkEn = 1'b0;
            held = pins;
            t = strobes;
            repeat (20) @(negedge ref_clk);
            chk(pins, held);
            chk(strobes, t);
            clkEn = 1'b1;
        end
        t = 0;
        while (busy !== 1'b0 && t < 20000) begin
            @(negedge ref_clk);
            t++;
        end
        chk(t < 20000, 1);
    endtask

    task automatic s_reset_values;
        chk(pins, 32'h120);
        chk(busy, 0);
    endtask

    task automatic s_fifo_full;
        int n;
        fill(2'h3, n);
        chk(n, FIFO_DEPTH);
        chk(lineReady, 0);
    endtask

    task automatic s_single_frame;
        frame(1'b0, 1'b0, 1, 1'b0);
        chk(v1Len, PH1_XFER_CYC + 1);
        chk(v2Len, VPULSE_CYC + 1);
        chk(v2s, ROWS);
        // The first two lines are binned, so one readout fewer.
        chk(falls, (ROWS - 1) * STAGES);
        chk(rsts, (ROWS - 1) * STAGES);
        chk(strobes, (ROWS - 1) * STAGES);
        chk(shuts, 1);
        chk(dumps, 1);
        chk(bHi, 0);
        chk(clash, 0);
        chk(lineBad, 0);
        chk(lineReady, 1);
    endtask

    task automatic s_exposure;
        int e1;
        // Exposure ends at the next frame's transfer, so it is read later.
        frame(1'b0, 1'b0, 2, 1'b0);
        frame(1'b0, 1'b0, 1, 1'b0);
        e1 = expo;
        chk(e1 > 0, 1);
        frame(1'b0, 1'b0, ROWS, 1'b0);
        chk(shuts, 0);
        chk(expo > e1, 1);
    endtask

    task automatic s_dual;
        int n;
        fill(2'h0, n);
        frame(1'b1, 1'b0, ROWS, 1'b0);
        chk(bHi > 0, 1);
        chk(clash, 0);
        chk(lineBad, 0);
    endtask

    task automatic s_single_output;
        int n;
        fill(2'h0, n);
        frame(1'b1, 1'b1, ROWS, 1'b0);
        chk(bHi, 0);
        chk(v2s, ROWS);
    endtask

    task automatic s_freeze;
        int n;
        fill(2'h0, n);
        frame(1'b0, 1'b0, ROWS, 1'b1);
        chk(falls, ROWS * STAGES);
    endtask

    initial begin
        repeat (50000) @(posedge ref_clk);
        errors++;
        wrap_up();
    end

    initial begin
        repeat (20) @(negedge ref_clk);
        s_reset_values();
        arst_n = 1'b1;
        s_fifo_full();
        s_single_frame();
        s_exposure();
        s_dual();
        s_single_output();
        s_freeze();
        wrap_up();
    end
endmodule
